// *** design/vrts_cfg.svh ***
/*
   Offsets, field positions, reset values and timing counts for the
   voltage reference / temperature sense control block.
   Assumes a 100 MHz system clock and a word-aligned AHB-Lite register map.
*/
`ifndef VRTS_CFG_SVH
`define VRTS_CFG_SVH

// register byte offsets (word aligned)
`define VRTS_CTRL_OFS      8'h00
`define VRTS_IRQ_STAT_OFS  8'h04
`define VRTS_IRQ_MASK_OFS  8'h08
`define VRTS_INFO_OFS      8'h0c

// control register fields
`define VRTS_REF_EN_BIT    7
`define VRTS_REF_RDY_BIT   6
`define VRTS_TS_EN_BIT     5
`define VRTS_TS_RNG_BIT    4
`define VRTS_CMP_GAIN_HI   3
`define VRTS_CMP_GAIN_LO   2
`define VRTS_CNV_GAIN_HI   1
`define VRTS_CNV_GAIN_LO   0
`define VRTS_CTRL_RESET    8'h00

// event bits (status and mask share the layout)
`define VRTS_EV_REF_READY  0
`define VRTS_EV_TEMP_ACQ   1
`define VRTS_EV_WIDTH      2

// timing
`define VRTS_CLK_MHZ       100
`define VRTS_TEMP_ACQ_US   200
`define VRTS_TEMP_ACQ_CYC  (`VRTS_TEMP_ACQ_US * `VRTS_CLK_MHZ)
`define VRTS_REF_SETTLE_CYC 1000

`endif

// *** design/vrts_pkg.sv ***
/*
   Types for the voltage reference / temperature sense control block.
   Assumes vrts_cfg.svh supplies every number.
*/
`default_nettype none

package vrts_pkg;

   // buffer gain codes of the two reference paths
   typedef enum logic [1:0] {
      GAIN_OFF = 2'b00,
      GAIN_X1  = 2'b01,
      GAIN_X2  = 2'b10,
      GAIN_X4  = 2'b11
   } vrts_gain_t;

   // reference settling states, gray along off -> settle -> ready
   typedef enum logic [1:0] {
      RS_OFF    = 2'b00,
      RS_SETTLE = 2'b01,
      RS_READY  = 2'b11
   } vrts_ref_state_t;

   // one-hot gain select: bit0 1x, bit1 2x, bit2 4x, zero when off
   function automatic logic [2:0] vrts_gain_onehot(input vrts_gain_t g);
      logic [2:0] r;
      r = 3'h0;
      case (g)
         GAIN_X1: r = 3'h1;
         GAIN_X2: r = 3'h2;
         GAIN_X4: r = 3'h4;
         default: r = 3'h0;
      endcase
      return r;
   endfunction : vrts_gain_onehot

endpackage : vrts_pkg

`default_nettype wire

// *** design/vrts_timer_if.sv ***
/*
   Carrier between the control logic and a settle timer.
   Assumes both ends share the block clock.
*/
`default_nettype none

interface vrts_timer_if;
   logic start;    // pulse: (re)load and run
   logic abort;    // level: hold idle, drop done
   logic running;  // level: counting
   logic done;     // level: elapsed and not aborted
   logic expired;  // pulse: the cycle done rises

   modport ctrl  (output start, output abort, input running, input done, input expired);
   modport timer (input start, input abort, output running, output done, output expired);
endinterface : vrts_timer_if

`default_nettype wire

// *** design/vrts_settle_timer.sv ***
/*
   Settle timer: counts CYCLES clock edges after start, then holds done.
   Assumes start and abort come from the block clock domain.
*/
`default_nettype none

module vrts_settle_timer
   import vrts_pkg::*;
#(
   parameter int CYCLES = 1000
)(
   input  wire logic     clock_in,
   input  wire logic     arst_n_in,
   vrts_timer_if.timer   tmr
);

   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] cnt_q, cnt_d;
   logic          run_q, run_d;
   logic          done_q, done_d;
   logic          exp_q, exp_d;

   // abort beats start so a disabled source never reports done
   always_comb
   begin
      cnt_d  = cnt_q;
      run_d  = run_q;
      done_d = done_q;
      exp_d  = 1'b0;
      if (tmr.abort)
      begin
         run_d  = 1'b0;
         done_d = 1'b0;
      end
      else if (tmr.start)
      begin
         cnt_d  = CW'(CYCLES - 1);
         run_d  = 1'b1;
         done_d = 1'b0;
      end
      else if (run_q)
      begin
         if (cnt_q == '0)
         begin
            run_d  = 1'b0;
            done_d = 1'b1;
            exp_d  = 1'b1;
         end
         else
            cnt_d = cnt_q - CW'(1);
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         cnt_q  <= '0;
         run_q  <= 1'b0;
         done_q <= 1'b0;
         exp_q  <= 1'b0;
      end
      else
      begin
         cnt_q  <= cnt_d;
         run_q  <= run_d;
         done_q <= done_d;
         exp_q  <= exp_d;
      end
   end

   assign tmr.running = run_q;
   assign tmr.done    = done_q;
   assign tmr.expired = exp_q;

   // done only ever rises out of a running count
   property p_done_from_run;
      @(posedge clock_in) disable iff (!arst_n_in)
      $rose(done_q) |-> $past(run_q) && exp_q;
   endproperty
   a_done_from_run: assert property (p_done_from_run) else $error("timer done without count");

endmodule : vrts_settle_timer

`default_nettype wire

// *** design/vrts_ctrl.sv ***
/*
   Voltage reference and temperature sense control block: AHB-Lite slave
   holding the control register, interrupt status/mask and an info word,
   the reference settling machine and the temperature acquisition guard.
   Assumes synchronous inputs, one clock, zero-wait single word transfers.
*/
// Overview of operation
// R1 - control bit 7 switches the fixed reference on or off
// R2 - ready flag reads 1 only when reference usable, else 0
// R3 - standard-voltage variant reads ready flag as constant 1
// R4 - control bit 5 switches the temperature indicator on or off
// R5 - control bit 4 picks high range when 1, low range when 0
// R6 - comparator gain field bits 3-2: 4x, 2x, 1x, 00 buffer off
// R7 - converter gain field bits 1-0: 4x, 2x, 1x, 00 buffer off
// R8 - all writable control bits reset to zero on every reset
// R9 - ready flag is read-only, writes to it are ignored
// R10 - software should clear both gain fields when reference is off
// R11 - software waits 200 us after routing converter mux to temperature
// R12 - software leaves 200 us between temperature conversions
// R13 - temperature output goes internally to a dedicated converter channel
// R14 - ready sets only after reference and amplifiers have settled
// R15 - buffer enable follows nonzero gain; decoded gain goes to buffer
`include "vrts_cfg.svh"
`default_nettype none

module vrts_ctrl
   import vrts_pkg::*;
#(
   parameter bit STD_VARIANT       = 1'b0,
   parameter int REF_SETTLE_CYCLES = `VRTS_REF_SETTLE_CYC,
   parameter int TEMP_ACQ_CYCLES   = `VRTS_TEMP_ACQ_CYC
)(
   input  wire logic        clock_in,
   input  wire logic        arst_n_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   input  wire logic        conv_temp_sel_in,
   input  wire logic        conv_done_in,
   output logic             ref_enable_out,
   output logic             ref_ready_out,
   output logic             temp_sensor_enable_out,
   output logic             temp_range_out,
   output logic             temp_to_converter_out,
   output logic             comp_buf_en_out,
   output logic      [2:0]  comp_gain_out,
   output logic             conv_buf_en_out,
   output logic      [2:0]  conv_gain_out,
   output logic             temp_acq_ok_out,
   output logic             irq_out
);

   localparam int EW = `VRTS_EV_WIDTH;

   vrts_timer_if ref_tmr ();
   vrts_timer_if acq_tmr ();

   // bus data-phase state
   logic             dvalid_q, dvalid_d;
   logic             dwrite_q, dwrite_d;
   logic [7:0]       daddr_q,  daddr_d;
   logic [31:0]      rdata_q,  rdata_d;

   // software-visible state
   logic             ref_en_q, ref_en_d;
   logic             ts_en_q,  ts_en_d;
   logic             ts_rng_q, ts_rng_d;
   vrts_gain_t       cmp_gain_q, cmp_gain_d;
   vrts_gain_t       cnv_gain_q, cnv_gain_d;
   logic [EW-1:0]    stat_q, stat_d;
   logic [EW-1:0]    mask_q, mask_d;

   // reference machine and event history
   vrts_ref_state_t  st_q, st_d;
   logic             rdy_prev_q;
   logic             sel_prev_q;
   logic             ready_bit;
   logic             ready_bit_d;
   logic             wr_ctrl;
   logic             wr_stat;
   logic             wr_mask;
   logic [EW-1:0]    ev_set;
   logic [7:0]       ctrl_view_d;

   // data-phase write strobes; hsize ignored, only whole words are used
   assign wr_ctrl = dvalid_q && dwrite_q && (daddr_q == `VRTS_CTRL_OFS);
   assign wr_stat = dvalid_q && dwrite_q && (daddr_q == `VRTS_IRQ_STAT_OFS);
   assign wr_mask = dvalid_q && dwrite_q && (daddr_q == `VRTS_IRQ_MASK_OFS);

   // software register updates; ready bit has no write path
   always_comb
   begin
      ref_en_d   = ref_en_q;
      ts_en_d    = ts_en_q;
      ts_rng_d   = ts_rng_q;
      cmp_gain_d = cmp_gain_q;
      cnv_gain_d = cnv_gain_q;
      mask_d     = mask_q;
      if (wr_ctrl)
      begin
         ref_en_d   = hwdata_in[`VRTS_REF_EN_BIT];                                    // R1 R9
         ts_en_d    = hwdata_in[`VRTS_TS_EN_BIT];                                     // R4
         ts_rng_d   = hwdata_in[`VRTS_TS_RNG_BIT];                                    // R5
         cmp_gain_d = vrts_gain_t'(hwdata_in[`VRTS_CMP_GAIN_HI:`VRTS_CMP_GAIN_LO]);   // R6
         cnv_gain_d = vrts_gain_t'(hwdata_in[`VRTS_CNV_GAIN_HI:`VRTS_CNV_GAIN_LO]);   // R7
      end
      if (wr_mask)
         mask_d = hwdata_in[EW-1:0];
   end

   // reference settling: timer runs from enable, aborted on disable
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         RS_OFF:
            if (ref_en_q)
               st_d = RS_SETTLE;
         RS_SETTLE:
            if (!ref_en_q)
               st_d = RS_OFF;
            else if (ref_tmr.done)
               st_d = RS_READY;                                     // R14
         RS_READY:
            if (!ref_en_q)
               st_d = RS_OFF;
         default:
            st_d = RS_OFF;
      endcase
   end

   assign ref_tmr.start = (st_q == RS_OFF) && ref_en_q;
   assign ref_tmr.abort = !ref_en_q;

   // standard variant has no settling report, flag sits high
   // gated by the enable so a disable drops the flag in the same cycle
   assign ready_bit   = STD_VARIANT ? 1'b1 : (st_q == RS_READY) && ref_en_q;    // R2 R3
   assign ready_bit_d = STD_VARIANT ? 1'b1 : (st_d == RS_READY) && ref_en_d;

   // acquisition guard restarts on mux arrival and after every conversion
   assign acq_tmr.start = conv_temp_sel_in && (!sel_prev_q || conv_done_in);
   assign acq_tmr.abort = !conv_temp_sel_in || !ts_en_q;

   // sticky events; a new event beats a same-cycle write-one clear
   assign ev_set[`VRTS_EV_REF_READY] = ready_bit && !rdy_prev_q;
   assign ev_set[`VRTS_EV_TEMP_ACQ]  = acq_tmr.expired;

   always_comb
   begin
      stat_d = stat_q;
      if (wr_stat)
         stat_d = stat_q & ~hwdata_in[EW-1:0];
      stat_d = stat_d | ev_set;
   end

   // bus address phase; read data built from next values so a read
   // right after a write returns the written value
   assign ctrl_view_d = {ref_en_d, ready_bit_d, ts_en_d, ts_rng_d, cmp_gain_d, cnv_gain_d};

   always_comb
   begin
      dvalid_d = hsel_in && htrans_in[1] && hready_in;
      dwrite_d = hwrite_in;
      daddr_d  = {haddr_in[7:2], 2'b00};
      rdata_d  = 32'h0;
      if (dvalid_d && !hwrite_in)
      begin
         case (daddr_d)
            `VRTS_CTRL_OFS:     rdata_d = {24'h0, ctrl_view_d};
            `VRTS_IRQ_STAT_OFS: rdata_d = {{(32-EW){1'b0}}, stat_d};
            `VRTS_IRQ_MASK_OFS: rdata_d = {{(32-EW){1'b0}}, mask_d};
            `VRTS_INFO_OFS:     rdata_d = {29'h0, acq_tmr.running, st_q == RS_SETTLE,
                                           acq_tmr.done};
            default:            rdata_d = 32'h0;   // unmapped reads zero
         endcase
      end
   end

   // all state: every writable control bit clears on any reset
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         dvalid_q   <= 1'b0;
         dwrite_q   <= 1'b0;
         daddr_q    <= 8'h00;
         rdata_q    <= 32'h0;
         ref_en_q   <= 1'b0;                                            // R8
         ts_en_q    <= 1'b0;                                            // R8
         ts_rng_q   <= 1'b0;                                            // R8
         cmp_gain_q <= GAIN_OFF;                                        // R8
         cnv_gain_q <= GAIN_OFF;                                        // R8
         stat_q     <= '0;
         mask_q     <= '0;
         st_q       <= RS_OFF;
         rdy_prev_q <= STD_VARIANT;
         sel_prev_q <= 1'b0;
      end
      else
      begin
         dvalid_q   <= dvalid_d;
         dwrite_q   <= dwrite_d;
         daddr_q    <= daddr_d;
         rdata_q    <= rdata_d;
         ref_en_q   <= ref_en_d;
         ts_en_q    <= ts_en_d;
         ts_rng_q   <= ts_rng_d;
         cmp_gain_q <= cmp_gain_d;
         cnv_gain_q <= cnv_gain_d;
         stat_q     <= stat_d;
         mask_q     <= mask_d;
         st_q       <= st_d;
         rdy_prev_q <= ready_bit;
         sel_prev_q <= conv_temp_sel_in;
      end
   end

   // output flops: analog controls lag the register by one cycle
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         hrdata_out             <= 32'h0;
         hreadyout_out          <= 1'b1;
         hresp_out              <= 1'b0;
         ref_enable_out         <= 1'b0;
         ref_ready_out          <= STD_VARIANT;
         temp_sensor_enable_out <= 1'b0;
         temp_range_out         <= 1'b0;
         temp_to_converter_out  <= 1'b0;
         comp_buf_en_out        <= 1'b0;
         comp_gain_out          <= 3'h0;
         conv_buf_en_out        <= 1'b0;
         conv_gain_out          <= 3'h0;
         temp_acq_ok_out        <= 1'b0;
         irq_out                <= 1'b0;
      end
      else
      begin
         hrdata_out             <= rdata_d;
         hreadyout_out          <= 1'b1;                                // zero wait states
         hresp_out              <= 1'b0;                                // always OKAY
         ref_enable_out         <= ref_en_q;                            // R1
         ref_ready_out          <= ready_bit;                           // R2
         temp_sensor_enable_out <= ts_en_q;                             // R4
         temp_range_out         <= ts_rng_q;                            // R5
         temp_to_converter_out  <= ts_en_q;                             // R13
         comp_buf_en_out        <= cmp_gain_q != GAIN_OFF;              // R6 R15
         comp_gain_out          <= vrts_gain_onehot(cmp_gain_q);        // R6 R15
         conv_buf_en_out        <= cnv_gain_q != GAIN_OFF;              // R7 R15
         conv_gain_out          <= vrts_gain_onehot(cnv_gain_q);        // R7 R15
         temp_acq_ok_out        <= acq_tmr.done;                        // R11 R12
         irq_out                <= |(stat_q & mask_q);
      end
   end

   // reference settle count; the figure is an analog estimate
   vrts_settle_timer #(.CYCLES(REF_SETTLE_CYCLES)) u_ref_timer (
      .clock_in  (clock_in),
      .arst_n_in (arst_n_in),
      .tmr       (ref_tmr)
   );

   // temperature acquisition count, 200 us at the block clock
   vrts_settle_timer #(.CYCLES(TEMP_ACQ_CYCLES)) u_acq_timer (
      .clock_in  (clock_in),
      .arst_n_in (arst_n_in),
      .tmr       (acq_tmr)
   );

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!arst_n_in);

   property p_ref_en_follow;
      wr_ctrl |=> ##1 ref_enable_out == $past(hwdata_in[`VRTS_REF_EN_BIT], 2);
   endproperty
   a_ref_en_follow: assert property (p_ref_en_follow) else $error("ref enable lost"); // R1

   property p_ready_needs_en;
      (!STD_VARIANT && ref_ready_out) |-> $past(ref_en_q) && $past(st_q == RS_READY);
   endproperty
   a_ready_needs_en: assert property (p_ready_needs_en) else $error("ready while off"); // R2

   property p_std_ready;
      STD_VARIANT |-> ref_ready_out && rdy_prev_q;
   endproperty
   a_std_ready: assert property (p_std_ready) else $error("variant ready low"); // R3

   property p_temp_follow;
      wr_ctrl |=> ##1 temp_sensor_enable_out == $past(hwdata_in[`VRTS_TS_EN_BIT], 2)
                   && temp_range_out == $past(hwdata_in[`VRTS_TS_RNG_BIT], 2);
   endproperty
   a_temp_follow: assert property (p_temp_follow) else $error("temp control lost"); // R4

   property p_cmp_gain;
      wr_ctrl |=> ##1 comp_buf_en_out == ($past(hwdata_in[3:2], 2) != 2'b00)
                   && comp_gain_out[2] == ($past(hwdata_in[3:2], 2) == 2'b11);
   endproperty
   a_cmp_gain: assert property (p_cmp_gain) else $error("comparator gain wrong"); // R6

   property p_cnv_gain;
      wr_ctrl |=> ##1 conv_buf_en_out == ($past(hwdata_in[1:0], 2) != 2'b00)
                   && conv_gain_out[0] == ($past(hwdata_in[1:0], 2) == 2'b01);
   endproperty
   a_cnv_gain: assert property (p_cnv_gain) else $error("converter gain wrong"); // R7

   property p_ready_ro;
      (!STD_VARIANT && $rose(ready_bit)) |-> $past(st_q) == RS_SETTLE;
   endproperty
   a_ready_ro: assert property (p_ready_ro) else $error("ready moved by write"); // R9

   property p_settle_first;
      (st_q == RS_OFF && ref_en_q) |=> st_q == RS_SETTLE ##1 st_q != RS_READY;
   endproperty
   a_settle_first: assert property (p_settle_first) else $error("ready without settle"); // R14

   property p_irq_level;
      |(stat_q & mask_q) |=> irq_out;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq not raised");

endmodule : vrts_ctrl

`default_nettype wire

// *** dv/vrts_tb.sv ***
/*
   Self-checking bench for the reference / temperature sense control block.
   Assumes the design's AHB-Lite slave answers with zero wait states and that
   the settle and acquisition counts are shortened through parameters.
*/
`include "vrts_cfg.svh"
`default_nettype none

module tb
   import vrts_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int REF_CYC = 8;
   localparam int ACQ_CYC = 16;

   logic        clock_in;
   logic        arst_n_in;
   logic        hsel_in;
   logic [31:0] haddr_in;
   logic [1:0]  htrans_in;
   logic        hwrite_in;
   logic [31:0] hwdata_in;
   logic        sel_in;
   logic        done_in;
   wire  [31:0] hrdata_out;
   wire         hready;
   wire         hresp_out;
   wire         ref_en, ref_rdy, ts_en, ts_rng, ts_conv, cmp_en, cnv_en, acq_ok, irq;
   wire  [2:0]  cmp_g, cnv_g;
   wire         std_rdy;
   int          errors;
   int          comparisons;
   logic [31:0] rd;
   int          cnt;

   // compare and count; never let an unknown pass
   `define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end

   vrts_ctrl #(.STD_VARIANT(1'b0), .REF_SETTLE_CYCLES(REF_CYC), .TEMP_ACQ_CYCLES(ACQ_CYC))
   vrts_ctrl_i (.clock_in(clock_in), .arst_n_in(arst_n_in), .hsel_in(hsel_in),
      .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
      .hwdata_in(hwdata_in), .hready_in(hready), .hrdata_out(hrdata_out),
      .hreadyout_out(hready), .hresp_out(hresp_out), .conv_temp_sel_in(sel_in),
      .conv_done_in(done_in), .ref_enable_out(ref_en), .ref_ready_out(ref_rdy),
      .temp_sensor_enable_out(ts_en), .temp_range_out(ts_rng),
      .temp_to_converter_out(ts_conv), .comp_buf_en_out(cmp_en), .comp_gain_out(cmp_g),
      .conv_buf_en_out(cnv_en), .conv_gain_out(cnv_g), .temp_acq_ok_out(acq_ok),
      .irq_out(irq));

   // second copy as the standard-voltage variant, fed the same traffic
   vrts_ctrl #(.STD_VARIANT(1'b1), .REF_SETTLE_CYCLES(REF_CYC), .TEMP_ACQ_CYCLES(ACQ_CYC))
   vrts_ctrl_std_i (.clock_in(clock_in), .arst_n_in(arst_n_in), .hsel_in(hsel_in),
      .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
      .hwdata_in(hwdata_in), .hready_in(hready), .hrdata_out(), .hreadyout_out(),
      .hresp_out(), .conv_temp_sel_in(sel_in), .conv_done_in(done_in),
      .ref_enable_out(), .ref_ready_out(std_rdy), .temp_sensor_enable_out(),
      .temp_range_out(), .temp_to_converter_out(), .comp_buf_en_out(), .comp_gain_out(),
      .conv_buf_en_out(), .conv_gain_out(), .temp_acq_ok_out(), .irq_out());

   // free-running 100 MHz clock
   initial
   begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end

   // one bus transfer: address phase, then data phase, each held until hready
   task automatic ahb_xfer(input logic [7:0] addr, input logic wr, input logic [31:0] wd);
      hsel_in   <= 1'b1;
      haddr_in  <= {24'h0, addr};
      htrans_in <= 2'h2;
      hwrite_in <= wr;
      // only the watchdog ends a wait for hready
      do @(posedge clock_in); while (hready !== 1'b1);
      htrans_in <= 2'h0;
      hwdata_in <= wd;
      do @(posedge clock_in); while (hready !== 1'b1);
      rd = hrdata_out;
      `CHK(hresp_out, 1'b0)
   endtask : ahb_xfer

   task automatic ahb_write(input logic [7:0] addr, input logic [31:0] wd);
      ahb_xfer(addr, 1'b1, wd);
   endtask : ahb_write

   task automatic ahb_read(input logic [7:0] addr, input logic [31:0] exp);
      ahb_xfer(addr, 1'b0, 32'h0);
      `CHK(rd, exp)
   endtask : ahb_read

   task automatic tally_and_finish;
      if (errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish

   // watchdog well beyond the roughly 110 cycles the tests need
   initial
   begin
      repeat (20000) @(posedge clock_in);
      errors++;
      tally_and_finish();
   end

   // main sequence
   initial
   begin
      errors = 0; comparisons = 0;
      arst_n_in = 1'b0; hsel_in = 1'b0; haddr_in = 32'h0; htrans_in = 2'h0;
      hwrite_in = 1'b0; hwdata_in = 32'h0; sel_in = 1'b0; done_in = 1'b0;
      repeat (2) @(posedge clock_in);
      arst_n_in <= 1'b1;
      `CHK(std_rdy, 1'b1)
      ahb_read(`VRTS_CTRL_OFS, 32'h0);
      ahb_read(8'h10, 32'h0);
      // all bits set: ready bit must stay clear while settling
      ahb_write(`VRTS_CTRL_OFS, 32'hff);
      ahb_read(`VRTS_CTRL_OFS, 32'hbf);
      repeat (2) @(posedge clock_in);
      `CHK({ref_en, ts_en, ts_rng, ts_conv}, 4'hf)
      `CHK({cmp_en, cmp_g, cnv_en, cnv_g}, 8'hcc)
      `CHK(std_rdy, 1'b1)
      // every gain code on both paths, fields in opposite order
      for (int g = 0; g < 4; g++)
      begin
         ahb_write(`VRTS_CTRL_OFS, {28'h000000a, 2'(g), 2'(3 - g)});
         repeat (2) @(posedge clock_in);
         `CHK({cmp_en, cmp_g}, {g != 0, (g == 0) ? 3'h0 : 3'(1 << (g - 1))})
         `CHK({cnv_en, cnv_g}, {g != 3, (g == 3) ? 3'h0 : 3'(1 << (2 - g))})
         `CHK({ts_en, ts_rng, ts_conv}, 3'h5)
      end
      ahb_write(`VRTS_CTRL_OFS, 32'h0);
      // reference off: ready low, then enable and time the settle
      repeat (2) @(posedge clock_in);
      `CHK(ref_rdy, 1'b0)
      ahb_write(`VRTS_CTRL_OFS, 32'h80);
      cnt = 0;
      while (ref_rdy !== 1'b1 && cnt < 100)
      begin
         @(posedge clock_in);
         cnt++;
      end
      `CHK(cnt >= REF_CYC && cnt <= REF_CYC + 4, 1'b1)
      ahb_read(`VRTS_CTRL_OFS, 32'hc0);
      // event with mask clear must not interrupt
      ahb_read(`VRTS_IRQ_STAT_OFS, 32'h1);
      `CHK(irq, 1'b0)
      ahb_write(`VRTS_IRQ_MASK_OFS, 32'h3);
      repeat (2) @(posedge clock_in);
      `CHK(irq, 1'b1)
      ahb_write(`VRTS_IRQ_STAT_OFS, 32'h1);
      repeat (2) @(posedge clock_in);
      `CHK(irq, 1'b0)
      ahb_read(`VRTS_IRQ_STAT_OFS, 32'h0);
      // dropping the enable drops ready
      ahb_write(`VRTS_CTRL_OFS, 32'h20);
      repeat (2) @(posedge clock_in);
      `CHK(ref_rdy, 1'b0)
      `CHK(std_rdy, 1'b1)
      // acquisition wait after the mux arrives, and between conversions
      for (int k = 0; k < 2; k++)
      begin
         if (k == 0)
            sel_in <= 1'b1;
         else
            done_in <= 1'b1;
         @(posedge clock_in);
         done_in <= 1'b0;
         // the registered ok flag lags the restart by two edges
         repeat (2) @(posedge clock_in);
         `CHK(acq_ok, 1'b0)
         cnt = 2;
         while (acq_ok !== 1'b1 && cnt < 100)
         begin
            @(posedge clock_in);
            cnt++;
         end
         `CHK(cnt >= ACQ_CYC - 1 && cnt <= ACQ_CYC + 4, 1'b1)
      end
      repeat (2) @(posedge clock_in);
      `CHK(irq, 1'b1)
      ahb_read(`VRTS_IRQ_STAT_OFS, 32'h2);
      ahb_read(`VRTS_INFO_OFS, 32'h1);
      // reset in mid-run clears every writable bit
      ahb_write(`VRTS_CTRL_OFS, 32'hbf);
      arst_n_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      `CHK({ref_en, ts_en, cmp_en, cnv_en, irq}, 5'h0)
      `CHK(std_rdy, 1'b1)
      arst_n_in <= 1'b1;
      sel_in <= 1'b0;
      ahb_read(`VRTS_CTRL_OFS, 32'h0);
      tally_and_finish();
   end
endmodule : tb

`default_nettype wire
